// >>> src/hps_top.sv
// design: host port synchronization and handshake, with transmit fifo

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module hps_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D]; // storage
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // pointers
    logic [AW:0] n_q, n_d; // fill count
    logic push, pop;
    // handshake terms
    always_comb begin
        in_ready = (n_q != (AW+1)'(D)); // room left
        out_valid = (n_q != '0);
        out_data = mem_q[rp_q];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + AW'(1) : wp_q;
        rp_d = pop ? rp_q + AW'(1) : rp_q;
        n_d = n_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    // pointer registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
            n_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            n_q <= n_d;
        end
    end
    // storage write, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule // hps_fifo

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module hps_top import hps_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // host pins, asynchronous
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_request_pin_n
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hps_pins_t pin1_q, pin2_q, pin3_q; // pin sync stages, then history
    logic [7:0] ctrl_q, ctrl_d; // interface_control_register
    logic host_command_bit_q, host_command_bit_d; // set by host, taken by core
    logic [V_W-1:0] host_vector_field_q, host_vector_field_d; // command vector
    logic [15:0] stage_q, stage_d; // high and middle transmit bytes
    logic [WORD_W-1:0] rxw_q, rxw_d; // host receive bytes
    logic rxf_q, rxf_d; // receive_full_flag
    logic cf2_q, cf2_d, cf3_q, cf3_d; // core flags to host
    hps_hbits_t hs1_q, hs2_q; // host bits into core domain
    logic [1:0] pair_q, pair_d; // agreed flag pair
    logic ap_q, ap_d; // ahb write pending data phase
    logic [7:0] apa_q, apa_d; // its byte address
    logic [31:0] rd_q, rd_d; // read data
    logic [7:0] dout_q, dout_d; // host read data
    logic oe_q, oe_d; // host data drive
    logic host_request_n_q, host_request_n_d; // request pin, active low
    // fifo and decode terms
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [WORD_W-1:0] f_in_data, f_out_data;
    logic wr_now, wr_was, rd_now, rd_was, a_take;
    logic [7:0] stat;
    hps_hbits_t hb;

    // ------------------------------------------------------------
    // transmit path buffer
    // ------------------------------------------------------------
    hps_fifo #(.W(WORD_W), .D(FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // next-state logic for the whole port
    always_comb begin
        ctrl_d = ctrl_q;
        host_command_bit_d = host_command_bit_q;
        host_vector_field_d = host_vector_field_q;
        stage_d = stage_q;
        rxw_d = rxw_q;
        rxf_d = rxf_q;
        cf2_d = cf2_q;
        cf3_d = cf3_q;
        pair_d = pair_q;
        rd_d = rd_q;
        dout_d = dout_q;
        f_in_valid = 1'b0;
        f_out_ready = 1'b0;
        f_in_data = {stage_q, pin3_q.data};
        // synced strobe levels, current and one cycle back
        wr_now = !pin2_q.cs_n && !pin2_q.wr_n;
        wr_was = !pin3_q.cs_n && !pin3_q.wr_n;
        rd_now = !pin2_q.cs_n && !pin2_q.rd_n;
        rd_was = !pin3_q.cs_n && !pin3_q.rd_n;
        a_take = hsel && htrans[1] && hready;
        ap_d = a_take && hwrite;
        apa_d = a_take ? haddr[7:0] : apa_q;
        // host status byte, live core-side bits [R4]
        stat = '0;
        stat[S_RXF] = rxf_q;
        stat[S_TXE] = f_in_ready;
        stat[S_TRANSMITTER_READY_FLAG] = f_in_ready && !f_out_valid;
        stat[S_CF2] = cf2_q;
        stat[S_CF3] = cf3_q;
        stat[S_HOST_REQUEST_PIN] = !host_request_n_q;
        // init completes one cycle after it is seen [R8] [R9]
        if (ctrl_q[C_INIT]) begin
            ctrl_d[C_INIT] = 1'b0;
            stage_d = '0;
        end
        // host write ends: act on the settled address and data
        if (wr_was && !wr_now) begin
            unique case (pin3_q.addr)
                HA_CTRL: ctrl_d = pin3_q.data;
                HA_CMD: begin
                    // a cleared command bit cancels; core may already have it [R6]
                    host_command_bit_d = pin3_q.data[K_HOST_COMMAND_BIT];
                    host_vector_field_d = pin3_q.data[V_LSB +: V_W];
                end
                HA_HIGH: stage_d[15:8] = pin3_q.data;
                HA_MID: stage_d[7:0] = pin3_q.data;
                // low byte moves the word toward the core [R3]
                HA_LOW: f_in_valid = 1'b1;
                default: ;
            endcase
        end
        // host read starts: capture the addressed byte
        if (rd_now && !rd_was) begin
            unique case (pin2_q.addr)
                HA_CTRL: dout_d = ctrl_q;
                HA_CMD: dout_d = {host_command_bit_q, 2'h0, host_vector_field_q};
                HA_STAT: dout_d = stat;
                HA_HIGH: dout_d = rxw_q[23:16];
                HA_MID: dout_d = rxw_q[15:8];
                HA_LOW: dout_d = rxw_q[7:0];
                default: dout_d = '0;
            endcase
        end
        // low byte read done empties the receive bytes [R1]
        if (rd_was && !rd_now && pin3_q.addr == HA_LOW) begin
            rxf_d = 1'b0;
        end
        // init also empties the host receive side
        if (ctrl_q[C_INIT]) begin
            rxf_d = 1'b0;
        end
        oe_d = rd_now;
        // ahb write data phase
        if (ap_q) begin
            unique case (apa_q)
                CA_CTRL: begin
                    cf2_d = hwdata[K_CF2];
                    cf3_d = hwdata[K_CF3];
                end
                CA_TX: begin
                    rxw_d = hwdata[WORD_W-1:0];
                    rxf_d = 1'b1; // set wins over host clear
                end
                default: ;
            endcase
        end
        // core takes the command; a new host set the same cycle wins
        if (ap_q && apa_q == CA_CTRL && hwdata[K_ACK]) begin
            if (!(wr_was && !wr_now && pin3_q.addr == HA_CMD)) begin
                host_command_bit_d = 1'b0;
            end
        end
        // agree the flag pair only on two equal samples [R11]
        if ({hs2_q.host_flag_one, hs2_q.host_flag_zero}
                == {hb.host_flag_one, hb.host_flag_zero}) begin
            pair_d = {hs2_q.host_flag_one, hs2_q.host_flag_zero};
        end
        // ahb read, registered at the address phase
        if (a_take && !hwrite) begin
            rd_d = '0;
            unique case (haddr[7:0])
                CA_CTRL: rd_d[K_CF3:K_CF2] = {cf3_q, cf2_q};
                CA_STAT: begin
                    rd_d[T_CORE_TRANSMIT_EMPTY_FLAG] = !rxf_q;
                    rd_d[T_CORE_RECEIVE_FULL_FLAG] = f_out_valid;
                    rd_d[T_COMMAND_PENDING_FLAG] = hs2_q.host_command_bit;
                    rd_d[T_PAIR +: 2] = pair_q;
                    rd_d[T_VEC +: V_W] = host_vector_field_q;
                end
                CA_RX: begin
                    rd_d[WORD_W-1:0] = f_out_data;
                    f_out_ready = 1'b1;
                end
                default: ;
            endcase
        end
        // request pin follows the enables
        host_request_n_d = !((ctrl_q[C_RECEIVE_REQUEST_ENABLE] && rxf_q)
            || (ctrl_q[C_TRANSMIT_REQUEST_ENABLE] && f_in_ready));
    end

    // host-side bits gathered before their crossing stage
    always_comb begin
        hb.init = ctrl_q[C_INIT];
        hb.transmit_request_enable = ctrl_q[C_TRANSMIT_REQUEST_ENABLE];
        hb.receive_request_enable = ctrl_q[C_RECEIVE_REQUEST_ENABLE];
        hb.host_flag_one = ctrl_q[C_HOST_FLAG_ONE];
        hb.host_flag_zero = ctrl_q[C_HOST_FLAG_ZERO];
        hb.host_command_bit = host_command_bit_q;
    end

    // pin synchronizers and host-bit stages, each bit alone [R10]
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin1_q <= '1;
            pin2_q <= '1;
            pin3_q <= '1;
            hs1_q <= '0;
            hs2_q <= '0;
        end else begin
            pin1_q <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in};
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
            hs1_q <= hb;
            hs2_q <= hs1_q;
        end
    end

    // port state registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q <= '0;
            host_command_bit_q <= 1'b0;
            host_vector_field_q <= '0;
            stage_q <= '0;
            rxw_q <= '0;
            rxf_q <= 1'b0;
            cf2_q <= 1'b0;
            cf3_q <= 1'b0;
            pair_q <= '0;
            ap_q <= 1'b0;
            apa_q <= '0;
            rd_q <= '0;
            dout_q <= '0;
            oe_q <= 1'b0;
            host_request_n_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            host_command_bit_q <= host_command_bit_d;
            host_vector_field_q <= host_vector_field_d;
            stage_q <= stage_d;
            rxw_q <= rxw_d;
            rxf_q <= rxf_d;
            cf2_q <= cf2_d;
            cf3_q <= cf3_d;
            pair_q <= pair_d;
            ap_q <= ap_d;
            apa_q <= apa_d;
            rd_q <= rd_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            host_request_n_q <= host_request_n_d;
        end
    end

    // bus and pin outputs from flops, except hreadyout and hresp which are constants
    always_comb begin
        hreadyout = 1'b1; // zero wait states
        hresp = 1'b0;
        hrdata = rd_q;
        host_data_out = dout_q;
        host_data_oe = oe_q;
        host_request_pin_n = host_request_n_q;
    end
endmodule // hps_top

// >>> src/hps_pkg.sv
// package: constants and carriers for the host port handshake block
//
// Functional notes
// [R1] host reads receive bytes only after full flag
// [R2] host writes transmit bytes only while empty
// [R3] host transmit bytes move into core receive register
// [R4] core-driven status readable by host any time
// [R5] host changes vector only while command clear
// [R6] host may cancel command; core may still run
// [R7] host never changes vector while clearing command
// [R8] init: set bit, poll clear, read status
// [R9] alternate init writes request enables with init
// [R10] host-side bits synchronized singly into core domain
// [R11] flag pair accepted only when two samples agree
package hps_pkg;
    // ------------------------------------------------------------
    // host-side register addresses (pin address bus)
    // ------------------------------------------------------------
    localparam logic [2:0] HA_CTRL = 3'h0; // interface_control_register
    localparam logic [2:0] HA_CMD = 3'h1; // command: host_command_bit + vector
    localparam logic [2:0] HA_STAT = 3'h2; // interface_status_register
    localparam logic [2:0] HA_HIGH = 3'h5; // byte high
    localparam logic [2:0] HA_MID = 3'h6; // byte middle
    localparam logic [2:0] HA_LOW = 3'h7; // byte low, completes a word
    // control register fields
    localparam int C_RECEIVE_REQUEST_ENABLE = 0; // receive_request_enable
    localparam int C_TRANSMIT_REQUEST_ENABLE = 1; // transmit_request_enable
    localparam int C_HOST_FLAG_ZERO = 3; // host_flag_zero
    localparam int C_HOST_FLAG_ONE = 4; // host_flag_one
    localparam int C_INIT = 7; // initialize bit
    // command register fields
    localparam int V_LSB = 0; // host_vector_field low bit
    localparam int V_W = 5; // vector width
    localparam int K_HOST_COMMAND_BIT = 7; // host_command_bit
    // status register fields
    localparam int S_RXF = 0; // receive_full_flag
    localparam int S_TXE = 1; // transmit_empty_flag
    localparam int S_TRANSMITTER_READY_FLAG = 2; // transmitter_ready_flag
    localparam int S_CF2 = 3; // core_flag_two
    localparam int S_CF3 = 4; // core_flag_three
    localparam int S_HOST_REQUEST_PIN = 7; // request pin asserted
    // ------------------------------------------------------------
    // core-side ahb register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CA_CTRL = 8'h00; // core flags, command ack
    localparam logic [7:0] CA_STAT = 8'h04; // core status
    localparam logic [7:0] CA_RX = 8'h08; // core_receive_register (pops)
    localparam logic [7:0] CA_TX = 8'h0c; // word to host receive bytes
    localparam int K_CF2 = 0; // core ctrl: core_flag_two
    localparam int K_CF3 = 1; // core ctrl: core_flag_three
    localparam int K_ACK = 8; // core ctrl: write one takes command
    // core status fields
    localparam int T_CORE_TRANSMIT_EMPTY_FLAG = 0; // core_transmit_empty_flag
    localparam int T_CORE_RECEIVE_FULL_FLAG = 1; // core_receive_full_flag
    localparam int T_COMMAND_PENDING_FLAG = 2; // command_pending_flag
    localparam int T_PAIR = 3; // agreed flag pair, two bits
    localparam int T_VEC = 8; // host_vector_field read directly, five bits
    localparam int WORD_W = 24; // host word width
    localparam int FIFO_D = 16; // transmit path depth
    localparam int NSYNC = 6; // host-side bits crossing to core
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } hps_pins_t; // sampled host pin group
    typedef struct packed {
        logic init;
        logic transmit_request_enable;
        logic receive_request_enable;
        logic host_flag_one;
        logic host_flag_zero;
        logic host_command_bit;
    } hps_hbits_t; // host-side bits seen by the core
endpackage

// >>> verif/hps_properties.sv
// checker: port properties of the host port handshake block
module hps_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // ahb side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // host side
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_data_oe,
    input wire logic host_request_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // read address phase, start of a host read
    sequence s_rd_ap;
        hsel && htrans[1] && !hwrite && hready;
    endsequence
    sequence s_host_rd;
        $fell(host_rd_n) && !host_cs_n;
    endsequence
    a_zero_wait: assert property (
        hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (
        !hresp) else $error("hresp not okay");
    a_unmapped_zero: assert property (
        s_rd_ap ##0 haddr == 32'h10 |=> hrdata == 32'h0) else $error("unmapped not zero");
    a_rdata_hold: assert property (
        !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata)) else $error("hrdata moved");
    a_oe_rises: assert property (
        s_host_rd |-> ##[1:4] host_data_oe) else $error("host read unanswered");
    a_oe_cause: assert property (
        $rose(host_data_oe) |-> !host_rd_n && !host_cs_n && !$past(host_rd_n))
        else $error("oe without read");
    a_oe_quiet: assert property (
        (host_rd_n && host_cs_n)[*6] |-> !host_data_oe) else $error("oe left on");
    a_idle_reset: assert property (
        $fell(reset) |-> host_request_pin_n && !host_data_oe) else $error("not idle at reset");
endmodule // hps_properties
bind hps_top hps_properties hps_properties_i (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_data_oe(host_data_oe), .host_request_pin_n(host_request_pin_n));

// >>> verif/hps_host_model.sv
// partner: host processor model driving the parallel port pins
module hps_host_model import hps_pkg::*; (
    // pacing clock
    input wire logic clk_sys,
    // host pins
    output logic host_cs_n,
    output logic host_rd_n,
    output logic host_wr_n,
    output logic [2:0] host_addr,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        host_addr = 3'h0;
        host_data_in = 8'h00;
    end
    // one access: strobes low, wait for the answer, release, scramble bus
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] di,
                       output logic [7:0] d);
        host_addr <= a;
        host_data_in <= di;
        {host_cs_n, host_rd_n, host_wr_n} <= w ? 3'h2 : 3'h1;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 12 && !w && host_data_oe !== 1'b1; i++) @(posedge clk_sys);
        d = (host_data_oe === 1'b1) ? host_data_out : ~host_data_out; // undriven bus is junk
        {host_cs_n, host_rd_n, host_wr_n} <= 3'h7;
        repeat (4) @(posedge clk_sys);
        host_data_in <= ~di; // no stale byte after hold
        host_addr <= ~a;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] di);
        logic [7:0] d;
        acc(1'b1, a, di, d);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h5a, d);
    endtask
    // re-read until masked bits match v, at most 40 reads, a changing bit is caught next pass
    task automatic poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v,
                        output logic [7:0] d);
        for (int i = 0; i < 40; i++) begin
            rd(a, d);
            if ((d & m) === v) break;
        end
    endtask
    task automatic send(input logic [23:0] w);
        logic [7:0] s;
        poll(HA_STAT, 8'h02, 8'h02, s);
        wr(HA_HIGH, w[23:16]);
        wr(HA_MID, w[15:8]);
        wr(HA_LOW, w[7:0]);
    endtask
    task automatic recv(output logic [23:0] w);
        logic [7:0] s;
        poll(HA_STAT, 8'h01, 8'h01, s);
        rd(HA_HIGH, s);
        w[23:16] = s;
        rd(HA_MID, s);
        w[15:8] = s;
        rd(HA_LOW, s);
        w[7:0] = s;
    endtask
endmodule // hps_host_model

// >>> verif/test_host_port_sync_handshake.sv
// testbench: host port handshake with core bus master and host model
module test_host_port_sync_handshake import hps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready, hreadyout, hresp, host_cs_n, host_rd_n, host_wr_n;
    wire logic host_data_oe, host_request_pin_n;
    wire logic [31:0] hrdata;
    wire logic [2:0] host_addr;
    wire logic [7:0] host_data_in, host_data_out;
    int failures = 0;
    int num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    assign hready = hreadyout;
    hps_top hps_top_i (.clk_sys(clk_sys), .reset(reset), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .host_request_pin_n(host_request_pin_n));
    hps_host_model host_i (.clk_sys(clk_sys), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // single ahb transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    // poll core status until masked bits match
    task automatic pc(input string n, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] d;
        for (int i = 0; i < 40; i++) begin
            ahb(1'b0, 32'(CA_STAT), 32'h0, d);
            if ((d & m) === v) break;
        end
        chk(n, v, d & m);
    endtask
    function automatic logic [23:0] wv(input int i);
        return 24'h010203 * 24'(i + 1);
    endfunction
    task automatic t_reset();
        logic [31:0] d;
        logic [7:0] h;
        chk("request pin", 32'h1, 32'(host_request_pin_n));
        pc("core status", 32'h1f1f, 32'h1);
        ahb(1'b1, 32'h10, 32'hffff_ffff, d);
        ahb(1'b0, 32'h10, 32'h0, d);
        chk("unmapped", 32'h0, d);
        host_i.rd(HA_STAT, h);
        chk("host status", 32'h06, 32'(h & 8'h87));
    endtask
    task automatic t_init();
        logic [7:0] h;
        host_i.wr(HA_CTRL, 8'h80);
        host_i.poll(HA_CTRL, 8'h80, 8'h00, h);
        chk("init clear", 32'h0, 32'(h & 8'h80));
        host_i.rd(HA_STAT, h);
        chk("status", 32'h02, 32'(h & 8'h83));
        host_i.wr(HA_CTRL, 8'h83);
        host_i.poll(HA_CTRL, 8'h80, 8'h00, h);
        host_i.rd(HA_STAT, h);
        chk("request bit", 32'h80, 32'(h & 8'h80));
        chk("request pin", 32'h0, 32'(host_request_pin_n));
    endtask
    task automatic t_fill();
        logic [31:0] d;
        logic [7:0] h;
        for (int i = 0; i < FIFO_D; i++) begin
            host_i.send(wv(i));
        end
        host_i.poll(HA_STAT, 8'h02, 8'h00, h);
        chk("full", 32'h0, 32'(h & 8'h06));
        chk("request pin", 32'h1, 32'(host_request_pin_n));
        host_i.wr(HA_HIGH, 8'hee);
        host_i.wr(HA_LOW, 8'hee);
        pc("core full", 32'h2, 32'h2);
        for (int i = 0; i < FIFO_D; i++) begin
            ahb(1'b0, 32'(CA_RX), 32'h0, d);
            chk("core word", 32'(wv(i)), d & 32'h00ff_ffff);
        end
        pc("core empty", 32'h2, 32'h0);
    endtask
    task automatic t_to_host();
        logic [31:0] d;
        logic [23:0] w;
        logic [7:0] h;
        ahb(1'b1, 32'(CA_TX), 32'h00ab_cdef, d);
        pc("rx full", 32'h1, 32'h0);
        chk("request pin", 32'h0, 32'(host_request_pin_n));
        host_i.recv(w);
        chk("host word", 32'h00ab_cdef, 32'(w));
        pc("rx empty", 32'h1, 32'h1);
        ahb(1'b1, 32'(CA_CTRL), 32'h3, d);
        host_i.poll(HA_STAT, 8'h18, 8'h18, h);
        chk("core flags", 32'h18, 32'(h & 8'h18));
        ahb(1'b1, 32'(CA_CTRL), 32'h0, d);
        host_i.poll(HA_STAT, 8'h18, 8'h00, h);
        chk("flags off", 32'h0, 32'(h & 8'h18));
    endtask
    task automatic t_command();
        logic [31:0] d;
        logic [7:0] h;
        host_i.wr(HA_CMD, 8'h13);
        host_i.wr(HA_CMD, 8'h93);
        pc("pending", 32'h1f04, 32'h1304);
        host_i.wr(HA_CMD, 8'h13);
        pc("cancelled", 32'h4, 32'h0);
        host_i.wr(HA_CMD, 8'h93);
        pc("pending", 32'h4, 32'h4);
        ahb(1'b1, 32'(CA_CTRL), 32'h100, d);
        host_i.poll(HA_CMD, 8'h80, 8'h00, h);
        chk("taken", 32'h13, 32'(h));
        pc("idle", 32'h4, 32'h0);
    endtask
    task automatic t_pair();
        for (int i = 0; i < 4; i++) begin
            host_i.wr(HA_CTRL, 8'(i * 8) | 8'h03);
            pc("flag pair", 32'h18, 32'(i * 8));
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_init();
        t_fill();
        t_to_host();
        t_command();
        t_pair();
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        summarize();
    end
endmodule // test_host_port_sync_handshake
